// [src/rcc_top.sv]
module rcc_top #(
  parameter int TICKS_PER_SEC = rcc_pkg::XTAL_HZ
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [rcc_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [rcc_pkg::DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [rcc_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // interrupt
  output logic irq_o,
  // crystal input and output pin
  input wire logic sosc_i,
  output logic rtc_pin_o,
  output logic rtc_pin_oe_o
);
  import rcc_pkg::*;

  typedef struct packed {
    logic xtal_q;
    logic [PRESC_W-1:0] presc;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] day;
    logic [7:0] mon;
    logic [7:0] year;
    logic [7:0] a_sec;
    logic [7:0] a_min;
    logic [7:0] a_hour;
    logic [7:0] a_wday;
    logic [7:0] a_day;
    logic [7:0] a_mon;
    logic rtc_module_on;
    logic wren;
    logic oe;
    logic [7:0] cal;
    logic [1:0] tptr;
    logic [1:0] aptr;
    logic alen;
    logic osel;
    rcc_key_t key;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic alarm_hold;
    logic pin;
    logic [DATA_W-1:0] prdata;
  } rcc_state_t;

  localparam rcc_state_t STATE_RST = '{
    xtal_q: 1'b0, presc: '0, sec: BCD_ZERO, min: BCD_ZERO, hour: BCD_ZERO,
    wday: BCD_ZERO, day: DAY_RST, mon: MON_RST, year: BCD_ZERO,
    a_sec: BCD_ZERO, a_min: BCD_ZERO, a_hour: BCD_ZERO, a_wday: BCD_ZERO,
    a_day: DAY_RST, a_mon: MON_RST, rtc_module_on: 1'b0, wren: 1'b0, oe: 1'b0,
    cal: CAL_RST, tptr: PTR_RST, aptr: PTR_RST, alen: 1'b0, osel: 1'b0,
    key: KEY_IDLE, int_stat: '0, int_mask: '0, alarm_hold: 1'b0, pin: 1'b0,
    prdata: '0
  };

  localparam logic [PRESC_W-1:0] TERM_NOM = PRESC_W'(TICKS_PER_SEC - 1);
  localparam logic [PRESC_W-1:0] HALF_CNT = PRESC_W'(TICKS_PER_SEC / 2);

  rcc_state_t s;
  rcc_state_t next_s;

  // bcd increment, returns {carry, value}; anything at or past max wraps
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] max,
                                         input logic [7:0] min);
    if (v >= max) begin
      return {1'b1, min};
    end
    if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // last day of month, BCD; year is the two low digits of 20yy
  function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] year);
    logic leap;
    leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                   : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
    case (mon)
      8'h02: month_len = leap ? DAY_FEB_LEAP : DAY_FEB;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = DAY_SHORT;
      default: month_len = DAY_LONG;
    endcase
  endfunction : month_len

  logic xtal_rise;
  logic [PRESC_W-1:0] term;
  logic sec_tick;
  logic half;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic acc_time;
  logic acc_alrm;
  logic wr_cfg;
  logic alarm_match;
  logic [8:0] inc;

  assign xtal_rise = sosc_i & ~s.xtal_q;
  assign half = s.presc >= HALF_CNT;
  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i;
  assign wr = access & pwrite_i;
  assign rd = access & ~pwrite_i;
  assign acc_time = access && paddr_i == ADDR_TIMEVAL;
  assign acc_alrm = access && paddr_i == ADDR_ALRMVAL;
  assign wr_cfg = wr && paddr_i == ADDR_CFGCAL;
  assign mapped = paddr_i == ADDR_CFGCAL || paddr_i == ADDR_TIMEVAL ||
                  paddr_i == ADDR_ALCFG || paddr_i == ADDR_ALRMVAL ||
                  paddr_i == ADDR_KEY || paddr_i == ADDR_INT_STAT ||
                  paddr_i == ADDR_INT_MASK;

  // calibration is applied once a minute: a positive value shortens the
  // last second of the minute by that many crystal ticks, negative stretches it
  always_comb begin
    if (s.sec == SEC_MAX) begin
      term = TERM_NOM - {{(PRESC_W - 8){s.cal[7]}}, s.cal};
    end else begin
      term = TERM_NOM;
    end
  end

  assign sec_tick = s.rtc_module_on & xtal_rise & (s.presc >= term);

  always_comb begin
    next_s = s;
    inc = '0;
    alarm_match = 1'b0;
    next_s.xtal_q = sosc_i;

    // time base and calendar
    if (sec_tick) begin
      next_s.presc = '0;
      inc = bcd_inc(s.sec, SEC_MAX, BCD_ZERO);
      next_s.sec = inc[7:0];
      if (inc[8]) begin
        inc = bcd_inc(s.min, SEC_MAX, BCD_ZERO);
        next_s.min = inc[7:0];
        if (inc[8]) begin
          inc = bcd_inc(s.hour, HOUR_MAX, BCD_ZERO);
          next_s.hour = inc[7:0];
          if (inc[8]) begin
            inc = bcd_inc(s.wday, WDAY_MAX, BCD_ZERO);
            next_s.wday = inc[7:0];
            inc = bcd_inc(s.day, month_len(s.mon, s.year), BCD_ONE);
            next_s.day = inc[7:0];
            if (inc[8]) begin
              inc = bcd_inc(s.mon, MON_MAX, BCD_ONE);
              next_s.mon = inc[7:0];
              if (inc[8]) begin
                inc = bcd_inc(s.year, YEAR_MAX, BCD_ZERO);
                next_s.year = inc[7:0];
              end
            end
          end
        end
      end
      // alarm compares the freshly advanced time
      alarm_match = s.alen && next_s.sec == s.a_sec && next_s.min == s.a_min &&
                    next_s.hour == s.a_hour && next_s.wday == s.a_wday &&
                    next_s.day == s.a_day && next_s.mon == s.a_mon;
      next_s.alarm_hold = alarm_match;
    end else if (s.rtc_module_on && xtal_rise) begin
      next_s.presc = s.presc + PRESC_W'(1);
    end

    // read data is prepared in the setup cycle, so the slave answers at once
    if (setup) begin
      case (paddr_i)
        ADDR_CFGCAL: begin
          next_s.prdata = '0;
          next_s.prdata[CFG_EN_BIT] = s.rtc_module_on;
          next_s.prdata[CFG_WREN_BIT] = s.wren;
          next_s.prdata[CFG_HALF_BIT] = half;
          next_s.prdata[CFG_OE_BIT] = s.oe;
          next_s.prdata[PTR_LO+1:PTR_LO] = s.tptr;
          next_s.prdata[7:0] = s.cal;
        end
        ADDR_TIMEVAL: begin
          case (s.tptr)
            2'h0: next_s.prdata = {16'h0000, s.min, s.sec};
            2'h1: next_s.prdata = {16'h0000, s.wday, s.hour};
            2'h2: next_s.prdata = {16'h0000, s.mon, s.day};
            default: next_s.prdata = {24'h000000, s.year};
          endcase
        end
        ADDR_ALCFG: begin
          next_s.prdata = '0;
          next_s.prdata[ALCFG_EN_BIT] = s.alen;
          next_s.prdata[ALCFG_OSEL_BIT] = s.osel;
          next_s.prdata[PTR_LO+1:PTR_LO] = s.aptr;
        end
        ADDR_ALRMVAL: begin
          case (s.aptr)
            2'h0: next_s.prdata = {16'h0000, s.a_min, s.a_sec};
            2'h1: next_s.prdata = {16'h0000, s.a_wday, s.a_hour};
            2'h2: next_s.prdata = {16'h0000, s.a_mon, s.a_day};
            default: next_s.prdata = '0;
          endcase
        end
        ADDR_INT_STAT: next_s.prdata = {{(DATA_W - INT_W){1'b0}}, s.int_stat};
        ADDR_INT_MASK: next_s.prdata = {{(DATA_W - INT_W){1'b0}}, s.int_mask};
        default: next_s.prdata = '0;
      endcase
    end

    // window reads step the pointer down, since word reads touch both bytes
    if (rd && paddr_i == ADDR_TIMEVAL && s.tptr != 2'h0) begin
      next_s.tptr = s.tptr - 2'h1;
    end
    if (rd && paddr_i == ADDR_ALRMVAL && s.aptr != 2'h0) begin
      next_s.aptr = s.aptr - 2'h1;
    end

    // the key window stays open for exactly one following transfer
    if (access) begin
      if (wr && paddr_i == ADDR_KEY && pstrb_i[0]) begin
        if (pwdata_i[7:0] == KEY_FIRST) begin
          next_s.key = KEY_GOT_FIRST;
        end else if (pwdata_i[7:0] == KEY_SECOND && s.key == KEY_GOT_FIRST) begin
          next_s.key = KEY_OPEN;
        end else begin
          next_s.key = KEY_IDLE;
        end
      end else begin
        next_s.key = KEY_IDLE;
      end
    end

    if (wr_cfg) begin
      if (pstrb_i[1]) begin
        next_s.rtc_module_on = pwdata_i[CFG_EN_BIT];
        next_s.oe = pwdata_i[CFG_OE_BIT];
        next_s.tptr = pwdata_i[PTR_LO+1:PTR_LO];
        // setting needs the open key window, or the bit already set
        next_s.wren = pwdata_i[CFG_WREN_BIT] & (s.key == KEY_OPEN | s.wren);
      end
      if (pstrb_i[0]) begin
        next_s.cal = pwdata_i[7:0];
      end
    end

    if (wr && acc_time && s.wren) begin
      case (s.tptr)
        2'h0: begin
          if (pstrb_i[0]) begin
            next_s.sec = pwdata_i[7:0];
            next_s.presc = '0;
          end
          if (pstrb_i[1]) begin
            next_s.min = pwdata_i[15:8];
          end
        end
        2'h1: begin
          if (pstrb_i[0]) begin
            next_s.hour = pwdata_i[7:0];
          end
          if (pstrb_i[1]) begin
            next_s.wday = pwdata_i[15:8];
          end
        end
        2'h2: begin
          if (pstrb_i[0]) begin
            next_s.day = pwdata_i[7:0];
          end
          if (pstrb_i[1]) begin
            next_s.mon = pwdata_i[15:8];
          end
        end
        default: begin
          if (pstrb_i[0]) begin
            next_s.year = pwdata_i[7:0];
          end
        end
      endcase
      if (pstrb_i[1] && s.tptr != 2'h0) begin
        next_s.tptr = s.tptr - 2'h1;
      end
    end

    if (wr && paddr_i == ADDR_ALCFG && pstrb_i[1]) begin
      next_s.alen = pwdata_i[ALCFG_EN_BIT];
      next_s.osel = pwdata_i[ALCFG_OSEL_BIT];
      next_s.aptr = pwdata_i[PTR_LO+1:PTR_LO];
    end

    if (wr && acc_alrm) begin
      case (s.aptr)
        2'h0: begin
          if (pstrb_i[0]) begin
            next_s.a_sec = pwdata_i[7:0];
          end
          if (pstrb_i[1]) begin
            next_s.a_min = pwdata_i[15:8];
          end
        end
        2'h1: begin
          if (pstrb_i[0]) begin
            next_s.a_hour = pwdata_i[7:0];
          end
          if (pstrb_i[1]) begin
            next_s.a_wday = pwdata_i[15:8];
          end
        end
        2'h2: begin
          if (pstrb_i[0]) begin
            next_s.a_day = pwdata_i[7:0];
          end
          if (pstrb_i[1]) begin
            next_s.a_mon = pwdata_i[15:8];
          end
        end
        default: begin
        end
      endcase
      if (pstrb_i[1] && s.aptr != 2'h0) begin
        next_s.aptr = s.aptr - 2'h1;
      end
    end

    if (wr && paddr_i == ADDR_INT_MASK && pstrb_i[0]) begin
      next_s.int_mask = pwdata_i[INT_W-1:0];
    end
    // write one to clear; a new event in the same cycle still sets
    if (wr && paddr_i == ADDR_INT_STAT && pstrb_i[0]) begin
      next_s.int_stat = s.int_stat & ~pwdata_i[INT_W-1:0];
    end
    next_s.int_stat[INT_ALARM] = next_s.int_stat[INT_ALARM] | alarm_match;
    next_s.int_stat[INT_SEC] = next_s.int_stat[INT_SEC] | sec_tick;

    // seconds clock is high for the first HALF_CNT crystal ticks of each second
    next_s.pin = next_s.oe & (s.osel ? (next_s.presc < HALF_CNT) : next_s.alarm_hold);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign prdata_o = s.prdata;
  assign pready_o = 1'b1;
  assign pslverr_o = access & ~mapped;
  assign irq_o = |(s.int_stat & s.int_mask);
  assign rtc_pin_o = s.pin;
  assign rtc_pin_oe_o = s.oe;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_tptr_write_dec: assert property (
    wr && acc_time && s.wren && pstrb_i[1] && s.tptr != 2'h0 |=> s.tptr == $past(s.tptr) - 2'h1)
    else $error("time pointer did not step down on high byte write");
  a_ptr_read_dec: assert property (
    rd && acc_alrm && s.aptr != 2'h0 |=> s.aptr == $past(s.aptr) - 2'h1)
    else $error("alarm pointer did not step down on read");
  a_ptr_hold_zero: assert property (
    (acc_alrm || acc_time) && s.aptr == 2'h0 && s.tptr == 2'h0
    |=> s.aptr == 2'h0 && s.tptr == 2'h0)
    else $error("pointer left 00 without reload");
  a_wren_gate: assert property (
    wr && acc_time && !s.wren && !sec_tick |=> s.sec == $past(s.sec) && s.year == $past(s.year))
    else $error("time window written while locked");
  a_wren_lock: assert property (
    wr_cfg && pstrb_i[1] && pwdata_i[CFG_WREN_BIT] && s.key != KEY_OPEN && !s.wren |=> !s.wren)
    else $error("write enable set without key sequence");
  a_key_window: assert property (
    s.key == KEY_OPEN && access |=> s.key != KEY_OPEN)
    else $error("key window open longer than one transfer");
  a_bcd_range: assert property (
    s.sec <= SEC_MAX && s.sec[3:0] <= 4'h9 && s.hour <= HOUR_MAX && s.year[3:0] <= 4'h9)
    else $error("time counter out of bcd range");
  a_day_wrap: assert property (
    sec_tick && s.sec == SEC_MAX && s.min == SEC_MAX && s.hour == HOUR_MAX && !wr
    |=> s.hour == BCD_ZERO && s.sec == BCD_ZERO && s.wday != $past(s.wday))
    else $error("midnight rollover wrong");
  a_tick_restart: assert property (
    sec_tick && !wr |=> s.presc == '0 ##1 s.presc <= PRESC_W'(1))
    else $error("prescaler did not restart after second");
  a_alarm_flag: assert property (
    alarm_match |=> s.int_stat[INT_ALARM] && s.alarm_hold)
    else $error("alarm match not flagged");

  c_wren_set: cover property (s.key == KEY_OPEN ##1 s.wren);
  c_alarm_fire: cover property (alarm_match);
  c_day_wrap: cover property (sec_tick && s.hour == HOUR_MAX && s.min == SEC_MAX &&
                              s.sec == SEC_MAX);
  c_ptr_walk: cover property (rd && acc_time && s.tptr == 2'h1 ##1 s.tptr == 2'h0);
endmodule : rcc_top

// [src/rcc_pkg.sv]
package rcc_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte addresses
  localparam logic [7:0] ADDR_CFGCAL = 8'h00;
  localparam logic [7:0] ADDR_TIMEVAL = 8'h04;
  localparam logic [7:0] ADDR_ALCFG = 8'h08;
  localparam logic [7:0] ADDR_ALRMVAL = 8'h0C;
  localparam logic [7:0] ADDR_KEY = 8'h10;
  localparam logic [7:0] ADDR_INT_STAT = 8'h14;
  localparam logic [7:0] ADDR_INT_MASK = 8'h18;
  // field positions
  localparam int CFG_EN_BIT = 15;
  localparam int CFG_WREN_BIT = 13;
  localparam int CFG_HALF_BIT = 11;
  localparam int CFG_OE_BIT = 10;
  localparam int PTR_LO = 8;
  localparam int ALCFG_EN_BIT = 15;
  localparam int ALCFG_OSEL_BIT = 14;
  localparam int INT_ALARM = 0;
  localparam int INT_SEC = 1;
  localparam int INT_W = 2;
  // unlock key sequence
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // time base
  localparam int XTAL_HZ = 32768;
  localparam int PRESC_W = 17;
  // counter limits, BCD
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] WDAY_MAX = 8'h06;
  localparam logic [7:0] MON_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] DAY_FEB = 8'h28;
  localparam logic [7:0] DAY_FEB_LEAP = 8'h29;
  localparam logic [7:0] DAY_SHORT = 8'h30;
  localparam logic [7:0] DAY_LONG = 8'h31;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  // reset values: 2000-01-01 00:00:00, weekday 0
  localparam logic [7:0] DAY_RST = 8'h01;
  localparam logic [7:0] MON_RST = 8'h01;
  localparam logic [1:0] PTR_RST = 2'h0;
  localparam logic [7:0] CAL_RST = 8'h00;

  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_GOT_FIRST,
    KEY_OPEN
  } rcc_key_t;
endpackage : rcc_pkg

// [tb/rcc_cpu_model.sv]
module rcc_cpu_model (
  // clock
  input wire logic clk_i,
  // apb master side
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [rcc_pkg::ADDR_W-1:0] paddr_o,
  output logic [rcc_pkg::DATA_W-1:0] pwdata_o,
  output logic [3:0] pstrb_o,
  input wire logic [rcc_pkg::DATA_W-1:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import rcc_pkg::*;
  logic [31:0] rdata;
  logic rerr;
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
    pstrb_o = 4'h0;
  end
  // request held until pready is seen high at a rising edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    pstrb_o <= s;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1) @(posedge clk_i);
    rdata = prdata_i;
    rerr = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    xfer(a, 1'b1, d, s);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    xfer(a, 1'b0, 32'h0000_0000, 4'h0);
  endtask : rd
  // key pair must be the two transfers just before the enable write
  task automatic unlock();
    wr(ADDR_KEY, {24'h000000, KEY_FIRST}, 4'h1);
    wr(ADDR_KEY, {24'h000000, KEY_SECOND}, 4'h1);
  endtask : unlock
endmodule : rcc_cpu_model

// [tb/rtc_calendar_pointer_access_tb.sv]
module rtc_calendar_pointer_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rcc_pkg::*;
  localparam int TPS = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sosc = 1'b0;
  logic [1:0] div = 2'h0;
  logic psel, penable, pwrite, pready, pslverr, irq, pin, pin_oe;
  logic half_seen = 1'b0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0 = 0;
  logic pin_hi = 1'b0;
  logic pin_lo = 1'b0;
  logic [7:0] yr [2] = '{8'h24, 8'h23};
  logic [15:0] md [2] = '{16'h0229, 16'h0301};

  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // slow crystal stand-in: one rise every 8 core cycles
  always @(posedge clk) begin
    div <= div + 2'h1;
    if (div == 2'h3) sosc <= ~sosc;
  end

  rcc_top #(.TICKS_PER_SEC(TPS)) dut (.core_clk_i(clk), .rst_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .irq_o(irq), .sosc_i(sosc), .rtc_pin_o(pin), .rtc_pin_oe_o(pin_oe));
  rcc_cpu_model cpu (.clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr));

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    cpu.rd(a);
    check(nm, exp, cpu.rdata);
  endtask : rc
  task automatic cfg(input logic en, input logic wren, input logic oe, input logic [1:0] p);
    cpu.wr(ADDR_CFGCAL, {16'h0000, en, 1'b0, wren, 2'b00, oe, p, 8'h00}, 4'h3);
  endtask : cfg
  // pointer starts at 3 so the four writes land year first, seconds last
  task automatic set_time(input logic [7:0] y, input logic [15:0] d, input logic [15:0] h,
                          input logic [15:0] ms);
    cfg(1'b0, 1'b1, 1'b0, 2'h3);
    cpu.wr(ADDR_TIMEVAL, {24'h000000, y}, 4'h3);
    cpu.wr(ADDR_TIMEVAL, {16'h0000, d}, 4'h3);
    cpu.wr(ADDR_TIMEVAL, {16'h0000, h}, 4'h3);
    cpu.wr(ADDR_TIMEVAL, {16'h0000, ms}, 4'h3);
  endtask : set_time
  task automatic wait_tick();
    int k;
    cpu.wr(ADDR_INT_STAT, 32'h0000_0003, 4'hF);
    for (k = 0; k < 100; k++) begin
      cpu.rd(ADDR_CFGCAL);
      if (cpu.rdata[CFG_HALF_BIT] === 1'b1) half_seen = 1'b1;
      cpu.rd(ADDR_INT_STAT);
      if (cpu.rdata[INT_SEC] === 1'b1) break;
    end
  endtask : wait_tick
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    check("irq", 32'h0, {31'h0, irq});
    check("pready", 32'h1, {31'h0, pready});
    rc(ADDR_CFGCAL, 32'h0000_0000, "cfg reset");
    cfg(1'b0, 1'b0, 1'b0, 2'h3);
    rc(ADDR_TIMEVAL, 32'h0000_0000, "year");
    rc(ADDR_TIMEVAL, 32'h0000_0101, "month day");
    rc(ADDR_TIMEVAL, 32'h0000_0000, "wday hour");
    rc(ADDR_TIMEVAL, 32'h0000_0000, "min sec");
    rc(ADDR_CFGCAL, 32'h0000_0000, "ptr after reads");
    cpu.rd(8'h1C);
    check("unmapped err", 32'h1, {31'h0, cpu.rerr});
    check("unmapped data", 32'h0, cpu.rdata);
    cfg(1'b0, 1'b0, 1'b0, 2'h3);
    cpu.wr(ADDR_TIMEVAL, 32'h0000_0012, 4'h3);
    rc(ADDR_CFGCAL, 32'h0000_0300, "locked ptr");
    rc(ADDR_TIMEVAL, 32'h0000_0000, "locked year");
    cpu.unlock();
    rc(ADDR_KEY, 32'h0000_0000, "key read");
    cfg(1'b0, 1'b1, 1'b0, 2'h3);
    rc(ADDR_CFGCAL, 32'h0000_0300, "late enable");
    cpu.unlock();
    cfg(1'b0, 1'b1, 1'b0, 2'h3);
    rc(ADDR_CFGCAL, 32'h0000_2300, "unlocked");
    set_time(8'h99, 16'h1231, 16'h0623, 16'h5958);
    rc(ADDR_CFGCAL, 32'h0000_2000, "ptr hold");
    cfg(1'b1, 1'b1, 1'b0, 2'h0);
    wait_tick();
    wait_tick();
    cfg(1'b0, 1'b1, 1'b0, 2'h3);
    rc(ADDR_TIMEVAL, 32'h0000_0000, "wrap year");
    rc(ADDR_TIMEVAL, 32'h0000_0101, "wrap date");
    rc(ADDR_TIMEVAL, 32'h0000_0000, "wrap wday hour");
    rc(ADDR_TIMEVAL, 32'h0000_0000, "wrap min sec");
    for (int i = 0; i < 2; i++) begin
      set_time(yr[i], 16'h0228, 16'h0023, 16'h5959);
      cfg(1'b1, 1'b1, 1'b0, 2'h0);
      wait_tick();
      cfg(1'b0, 1'b1, 1'b0, 2'h3);
      rc(ADDR_TIMEVAL, {24'h0, yr[i]}, "leap year");
      rc(ADDR_TIMEVAL, {16'h0, md[i]}, "leap date");
      rc(ADDR_TIMEVAL, 32'h0000_0100, "leap wday hour");
    end
    // a calibration of +4 ends the last second of the minute after half the ticks
    set_time(8'h00, 16'h0101, 16'h0000, 16'h0059);
    cpu.wr(ADDR_CFGCAL, 32'h0000_A004, 4'h3);
    t0 = cyc;
    wait_tick();
    check("cal short", 32'h1, {31'h0, (cyc - t0) < 48});
    cfg(1'b0, 1'b1, 1'b0, 2'h0);
    cpu.wr(ADDR_ALCFG, 32'h0000_8200, 4'h3);
    cpu.wr(ADDR_ALRMVAL, 32'h0000_0101, 4'h3);
    cpu.wr(ADDR_ALRMVAL, 32'h0000_0000, 4'h3);
    cpu.wr(ADDR_ALRMVAL, 32'h0000_0001, 4'h3);
    rc(ADDR_ALCFG, 32'h0000_8000, "alarm ptr hold");
    cpu.wr(ADDR_ALCFG, 32'h0000_8300, 4'h3);
    rc(ADDR_ALRMVAL, 32'h0000_0000, "alarm none");
    rc(ADDR_ALRMVAL, 32'h0000_0101, "alarm date");
    rc(ADDR_ALRMVAL, 32'h0000_0000, "alarm wday hour");
    rc(ADDR_ALRMVAL, 32'h0000_0001, "alarm min sec");
    cpu.wr(ADDR_INT_MASK, 32'h0000_0001, 4'hF);
    set_time(8'h00, 16'h0101, 16'h0000, 16'h0000);
    cfg(1'b1, 1'b1, 1'b1, 2'h0);
    wait_tick();
    check("status", 32'h3, {30'h0, cpu.rdata[1:0]});
    @(negedge clk);
    check("irq set", 32'h1, {31'h0, irq});
    check("pin", 32'h3, {30'h0, pin_oe, pin});
    cpu.wr(ADDR_INT_STAT, 32'h0000_0001, 4'hF);
    @(negedge clk);
    check("irq clear", 32'h0, {31'h0, irq});
    check("half second", 32'h1, {31'h0, half_seen});
    cfg(1'b1, 1'b0, 1'b1, 2'h0);
    rc(ADDR_CFGCAL, 32'h0000_8400, "relock");
    cpu.wr(ADDR_ALCFG, 32'h0000_4000, 4'h3);
    repeat (70) begin
      @(negedge clk);
      pin_hi = pin_hi | pin;
      pin_lo = pin_lo | ~pin;
    end
    check("seconds clock", 32'h3, {30'h0, pin_hi, pin_lo});
    report_and_stop();
  end
endmodule : rtc_calendar_pointer_access_tb
